// *** core/cfm_alu8.sv ***
// Purpose: 8-bit result and flag computation
// Assumes: Purely combinational, flags in cfm_cfg.svh layout
// Notes: aff marks the flag bits that the operation writes
`timescale 1ns/1ns
`default_nettype none
`include "cfm_cfg.svh"
module cfm_alu8 import cfm_pkg::*; (
  // Operation
  input wire cfm_op_e op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic [7:0] flags,
  // Result
  output logic [7:0] res,
  output logic [7:0] nflg,
  output logic [7:0] aff
);

  logic [8:0] s;
  logic [4:0] hs;
  logic ci;
  logic [7:0] cf;

  always_comb begin
    res = a;
    nflg = 8'h00;
    aff = 8'h00;
    s = 9'h000;
    hs = 5'h00;
    cf = 8'h00;
    ci = (op == OP_ADC || op == OP_SBC) ? flags[`CFM_BIT_C] : 1'b0;
    case (op)
      OP_ADD, OP_ADC: begin
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        hs = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        res = s[7:0];
        nflg[`CFM_BIT_V] = (a[7] == b[7]) && (res[7] != a[7]);
        nflg[`CFM_BIT_H] = hs[4];
        nflg[`CFM_BIT_C] = s[8];
        aff = 8'h97;
      end
      OP_SUB, OP_SBC: begin
        s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
        res = s[7:0];
        nflg[`CFM_BIT_V] = (a[7] != b[7]) && (res[7] != a[7]);
        nflg[`CFM_BIT_C] = s[8];
        aff = 8'h87;
      end
      OP_AND, OP_ORA, OP_EOR, OP_MOV: begin
        res = (op == OP_AND) ? (a & b) : (op == OP_ORA) ? (a | b) :
              (op == OP_EOR) ? (a ^ b) : b;
        aff = 8'h86;
      end
      OP_ASL, OP_ROL, OP_LSR, OP_ROR, OP_ASR: begin
        if (op == OP_ASL || op == OP_ROL) begin
          res = {a[6:0], (op == OP_ROL) & flags[`CFM_BIT_C]};
          nflg[`CFM_BIT_C] = a[7];
        end else begin
          res = {(op == OP_ROR) ? flags[`CFM_BIT_C] :
                 (op == OP_ASR) & a[7], a[7:1]};
          nflg[`CFM_BIT_C] = a[0];
        end
        nflg[`CFM_BIT_V] = res[7] ^ nflg[`CFM_BIT_C];
        aff = 8'h87;
      end
      OP_BTST: begin
        nflg[`CFM_BIT_C] = a[b[2:0]];
        aff = 8'h01;
      end
      OP_DEC_ADJ: begin
        // Correction picked from H, C and the digits
        cf[3:0] = (flags[`CFM_BIT_H] || a[3:0] > 4'h9) ? 4'h6 : 4'h0;
        cf[7:4] = (flags[`CFM_BIT_C] || a > 8'h99) ? 4'h6 : 4'h0;
        res = a + cf;
        nflg[`CFM_BIT_C] = flags[`CFM_BIT_C] || a > 8'h99;
        aff = 8'h07;
      end
      default: begin
        res = a;
      end
    endcase
    nflg[`CFM_BIT_N] = res[7];
    nflg[`CFM_BIT_Z] = (res == 8'h00);
  end

endmodule : cfm_alu8
`default_nettype wire

// *** core/cfm_cfg.svh ***
// Purpose: Constants for the flag and mask control block
// Assumes: 20 MHz core clock, APB register window of 16 bytes
// Notes: Definitions only
`ifndef CFM_CFG_SVH
`define CFM_CFG_SVH

// Register byte offsets
`define CFM_FLAGS_OFS 8'h00
`define CFM_CTRL_OFS 8'h04
`define CFM_STAT_OFS 8'h08
`define CFM_OSC_OFS 8'h0c

// Flag bit positions
`define CFM_BIT_C 0
`define CFM_BIT_Z 1
`define CFM_BIT_N 2
`define CFM_BIT_I 3
`define CFM_BIT_H 4
`define CFM_BIT_V 7

// Flag masks and reset value
`define CFM_ONES 8'h60
`define CFM_I_MASK 8'h08
`define CFM_FLAGS_RST 8'h68

// Vectors and opcode; opcode value is arbitrary
`define CFM_BRK_VEC 16'hfffc
`define CFM_MON_VEC 16'hfefc
`define CFM_TRAP_OPCODE 8'h00

// Timing
`define CFM_CLK_NS 50
`define CFM_OSC_DLY_NS 204800
`define CFM_OSC_DLY_CYC (`CFM_OSC_DLY_NS / `CFM_CLK_NS)
`define CFM_IMM_CYC 2

`endif

// *** core/cfm_flag_ctl.sv ***
// Purpose: Condition flags, interrupt mask, entry, sleep and break
// Assumes: Sequencer presents one operation per op_valid pulse
// Notes: APB slave answers with no wait state
//
// What this block does
// - Eight flag bits, bits 6 and 5 one
// - Overflow flag tracks two's complement overflow
// - Half carry from bit 3 on adds
// - Decimal adjust uses half carry and carry
// - Mask set blocks maskable interrupts
// - Entry pushes, then masks, then fetches vector
// - Entry stacking leaves index high byte out
// - Highest priority pending request served first
// - Return restores stacked flags including mask
// - Reset sets mask; clear, transfer to flags, return, wait and stop clear it
// - Negative flag copies result bit 7
// - Zero flag set on all-zero result
// - Carry from bit 7, borrow, shifts, tests
// - Wait clears mask, gates clock
// - Stop clears mask, gates clock
// - Stop exit waits oscillator delay
// - Break loads trap opcode and vector
// - Break starts at instruction end
// - Return ends break once request drops
// - Stack pointer add, sign extended, two cycles
// - Index add, sign extended, two cycles
`timescale 1ns/1ns
`default_nettype none
`include "cfm_cfg.svh"
module cfm_flag_ctl import cfm_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Operation from the sequencer
  input wire logic op_valid,
  input wire cfm_op_e op_code,
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  input wire logic instr_last,
  output logic [7:0] res,
  output logic [7:0] flags,
  output logic cond_lt,
  output logic cond_le,
  // Immediate adds
  input wire logic [15:0] sp_in,
  input wire logic [15:0] hx_in,
  output logic [15:0] imm_sum,
  output logic imm_done,
  // Interrupts and break
  input wire logic [7:0] irq_req,
  input wire logic ext_irq,
  input wire logic brk_req,
  output logic push_req,
  input wire logic push_done,
  output logic vec_req,
  input wire logic vec_done,
  output logic vec_brk,
  output logic [15:0] vec_addr,
  output logic [2:0] irq_id,
  output logic ir_load,
  output logic [7:0] ir_value,
  // Clock gating
  output logic clk_gate
);

  localparam cfm_state_s RST = '{
    flags: `CFM_FLAGS_RST,
    st: ST_RUN,
    osc_dly: 16'(`CFM_OSC_DLY_CYC),
    default: '0
  };

  cfm_state_s q;
  cfm_state_s n;
  logic [7:0] alu_res;
  logic [7:0] alu_flg;
  logic [7:0] alu_aff;
  logic [2:0] pri;
  logic op_take;
  logic sleep_op;
  logic apb_wr;
  logic hit;
  logic [31:0] rd_mux;
  logic [15:0] imm_base;

  cfm_alu8 i_cfm_alu8 (
    .op(op_code),
    .a(op_a),
    .b(op_b),
    .flags(q.flags),
    .res(alu_res),
    .nflg(alu_flg),
    .aff(alu_aff)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  assign op_take = op_valid && q.st == ST_RUN && q.imm_stage == 2'd0;
  assign sleep_op = op_take && (op_code == OP_WAIT || op_code == OP_STOP);
  assign apb_wr = psel && penable && pwrite;
  assign imm_base = (op_code == OP_SP_ADD) ? sp_in : hx_in;

  // Lowest index wins
  always_comb begin
    pri = 3'd0;
    for (int i = 7; i >= 0; i--) begin
      if (irq_req[i]) begin
        pri = 3'(i);
      end
    end
  end

  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `CFM_FLAGS_OFS: rd_mux = {24'h00_0000, q.flags};
      `CFM_CTRL_OFS: rd_mux = {31'h0000_0000, q.mon};
      `CFM_STAT_OFS: begin
        rd_mux = {26'h000_0000, q.st, q.gate, q.brk, |q.imm_stage};
      end
      `CFM_OSC_OFS: rd_mux = {16'h0000, q.osc_dly};
      default: hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = q;
    n.ir_load = 1'b0;
    if (psel && !penable) begin
      n.prdata = rd_mux;
    end
    if (apb_wr) begin
      case (paddr)
        // Bus cannot touch the mask; only clear, transfer to flags, return, wait and stop may clear it
        `CFM_FLAGS_OFS: begin
          n.flags = (pwdata[7:0] & ~`CFM_I_MASK) |
                    (q.flags & `CFM_I_MASK);
        end
        `CFM_CTRL_OFS: n.mon = pwdata[0];
        `CFM_OSC_OFS: n.osc_dly = pwdata[15:0];
        default: n.mon = q.mon;
      endcase
    end

    // Two-cycle immediate add, flags untouched
    case (q.imm_stage)
      2'd1: n.imm_stage = 2'd2;
      2'd2: n.imm_stage = 2'd0;
      default: n.imm_stage = 2'd0;
    endcase

    if (op_take) begin
      case (op_code)
        OP_SP_ADD, OP_IX_ADD: begin
          n.imm_sum = imm_base + {{8{op_b[7]}}, op_b};
          n.imm_stage = 2'd1;
        end
        OP_TAP: n.flags = op_b;
        OP_CLR_MASK: n.flags[`CFM_BIT_I] = 1'b0;
        OP_SEI: n.flags[`CFM_BIT_I] = 1'b1;
        OP_RET_IRQ: begin
          n.flags = op_b;
          if (q.brk && !brk_req) begin
            n.brk = 1'b0;
          end
        end
        OP_WAIT: begin
          n.flags[`CFM_BIT_I] = 1'b0;
          n.gate = 1'b1;
          n.st = ST_WAIT;
        end
        OP_STOP: begin
          n.flags[`CFM_BIT_I] = 1'b0;
          n.gate = 1'b1;
          n.st = ST_STOP;
        end
        default: begin
          n.res = alu_res;
          n.flags = (q.flags & ~alu_aff) | (alu_flg & alu_aff);
        end
      endcase
    end

    case (q.st)
      ST_RUN: begin
        if (sleep_op) begin
          n.irq_id = q.irq_id;
        end else if (brk_req && instr_last && !q.brk) begin
          // Break is not maskable and starts on the last cycle
          n.brk = 1'b1;
          n.ir_load = 1'b1;
          n.vec_brk = 1'b1;
          n.vec = q.mon ? `CFM_MON_VEC : `CFM_BRK_VEC;
          n.st = ST_PUSH;
        end else if (instr_last && !q.flags[`CFM_BIT_I] && |irq_req) begin
          n.irq_id = pri;
          n.vec_brk = 1'b0;
          n.vec = 16'h0000;
          n.st = ST_PUSH;
        end
      end
      ST_PUSH: begin
        if (push_done) begin
          n.st = ST_MASK;
        end
      end
      ST_MASK: begin
        n.flags[`CFM_BIT_I] = 1'b1;
        n.st = ST_VEC;
      end
      ST_VEC: begin
        if (vec_done) begin
          n.st = ST_RUN;
        end
      end
      ST_WAIT: begin
        // Any request wakes; mask stays clear
        if (|irq_req) begin
          n.gate = 1'b0;
          n.st = ST_RUN;
        end
      end
      ST_STOP: begin
        if (ext_irq) begin
          n.cnt = q.osc_dly;
          n.st = ST_OSC;
        end
      end
      ST_OSC: begin
        // A zero delay still costs one cycle
        if (q.cnt <= 16'd1) begin
          n.gate = 1'b0;
          n.st = ST_RUN;
        end else begin
          n.cnt = q.cnt - 16'd1;
        end
      end
      default: n.st = ST_RUN;
    endcase
    n.flags = n.flags | `CFM_ONES;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q <= RST;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign res = q.res;
  assign flags = q.flags;
  assign cond_lt = q.flags[`CFM_BIT_N] ^ q.flags[`CFM_BIT_V];
  assign cond_le = q.flags[`CFM_BIT_Z] | cond_lt;
  assign imm_sum = q.imm_sum;
  assign imm_done = (q.imm_stage == 2'd2);
  // Push set is PC, X, A and flags; index high byte is never stacked
  assign push_req = (q.st == ST_PUSH);
  assign vec_req = (q.st == ST_VEC);
  assign vec_brk = q.vec_brk;
  assign vec_addr = q.vec;
  assign irq_id = q.irq_id;
  assign ir_load = q.ir_load;
  assign ir_value = `CFM_TRAP_OPCODE;
  assign clk_gate = q.gate;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [7:0] chk_add;
  logic [4:0] chk_hc;
  logic [8:0] chk_c8;
  assign chk_add = op_a + op_b;
  assign chk_hc = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
  assign chk_c8 = {1'b0, op_a} + {1'b0, op_b};

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  AST_ONES: assert property (flags[6] && flags[5])
    else $error("flag bits 6 and 5 not one");
  AST_OVF: assert property (op_take && op_code == OP_ADD |=>
    flags[`CFM_BIT_V] == $past((op_a[7] == op_b[7]) &&
                               (chk_add[7] != op_a[7])))
    else $error("overflow flag wrong after add");
  AST_HALF: assert property (op_take && op_code == OP_ADD |=>
    flags[`CFM_BIT_H] == $past(chk_hc[4]))
    else $error("half carry wrong after add");
  AST_MASKED: assert property (
    q.st == ST_RUN && flags[`CFM_BIT_I] && !brk_req |=> q.st != ST_PUSH)
    else $error("masked request entered");
  AST_ENTRY: assert property (
    q.st == ST_PUSH && push_done |=> q.st == ST_MASK ##1
    (q.st == ST_VEC && flags[`CFM_BIT_I] && vec_req))
    else $error("entry order wrong");
  AST_CLRMASK: assert property ($fell(flags[`CFM_BIT_I]) |->
    $past(op_take && (op_code == OP_CLR_MASK || op_code == OP_RET_IRQ ||
                      op_code == OP_TAP || sleep_op)))
    else $error("mask cleared without instruction");
  AST_NZ: assert property (op_take && op_code == OP_AND |=>
    flags[`CFM_BIT_N] == $past(op_a[7] & op_b[7]) &&
    flags[`CFM_BIT_Z] == $past((op_a & op_b) == 8'h00))
    else $error("N or Z wrong after and");
  AST_CARRY: assert property (op_take && op_code == OP_ADD |=>
    flags[`CFM_BIT_C] == $past(chk_c8[8]))
    else $error("carry wrong after add");
  AST_WAIT: assert property (op_take && op_code == OP_WAIT |=>
    clk_gate && !flags[`CFM_BIT_I] && q.st == ST_WAIT)
    else $error("wait entry wrong");
  AST_OSC: assert property (q.st == ST_OSC |-> clk_gate)
    else $error("clock ungated during oscillator delay");
  AST_BRK: assert property (
    q.st == ST_RUN && brk_req && instr_last && !q.brk && !sleep_op |=>
    ir_load && vec_brk && push_req)
    else $error("break entry wrong");
  AST_IMM: assert property (
    op_take && (op_code == OP_SP_ADD || op_code == OP_IX_ADD) |->
    ##1 !imm_done ##1 imm_done)
    else $error("immediate add not done in two cycles");
  AST_STOP: assert property (op_take && op_code == OP_STOP |=>
    clk_gate && !flags[`CFM_BIT_I] && q.st == ST_STOP)
    else $error("stop entry wrong");
  AST_IMMFLAGS: assert property (
    op_take && !apb_wr && (op_code == OP_SP_ADD || op_code == OP_IX_ADD)
    |=> $stable(flags))
    else $error("immediate add changed flags");

endmodule : cfm_flag_ctl
`default_nettype wire

// *** core/cfm_pkg.sv ***
// Purpose: Types for the flag and mask control block
// Assumes: Constants live in cfm_cfg.svh
// Notes: None
package cfm_pkg;

  typedef enum logic [4:0] {
    OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_ORA, OP_EOR,
    OP_MOV, OP_ASL, OP_LSR, OP_ROL, OP_ROR, OP_ASR, OP_BTST,
    OP_DEC_ADJ, OP_TAP, OP_CLR_MASK, OP_SEI, OP_SP_ADD, OP_IX_ADD,
    OP_WAIT, OP_STOP, OP_RET_IRQ
  } cfm_op_e;

  // Gray along run, push, mask, vector
  typedef enum logic [2:0] {
    ST_RUN = 3'b000, ST_PUSH = 3'b001, ST_MASK = 3'b011,
    ST_VEC = 3'b010, ST_WAIT = 3'b110, ST_STOP = 3'b111,
    ST_OSC = 3'b101
  } cfm_state_e;

  typedef struct packed {
    logic [7:0] flags;
    cfm_state_e st;
    logic [15:0] cnt;
    logic [15:0] osc_dly;
    logic mon;
    logic [1:0] imm_stage;
    logic [15:0] imm_sum;
    logic [7:0] res;
    logic brk;
    logic gate;
    logic ir_load;
    logic [15:0] vec;
    logic vec_brk;
    logic [2:0] irq_id;
    logic [31:0] prdata;
  } cfm_state_s;

endpackage : cfm_pkg

// *** tb/cfm_flag_ctl_tb.sv ***
// Purpose: Self-checking bench for the flag and mask control block
// Assumes: APB slave with no wait state, sequencer ops one per pulse
// Notes: Inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ns
`default_nettype none
`include "cfm_cfg.svh"
module cfm_flag_ctl_tb import cfm_pkg::*;;
  logic clock = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, op_valid = 1'b0, instr_last = 1'b0;
  logic ext_irq = 1'b0, brk_req = 1'b0, push_done = 1'b0, vec_done = 1'b0;
  logic [7:0] paddr = 8'h00, op_a = 8'h00, op_b = 8'h00, irq_req = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [15:0] sp_in = 16'h1000, hx_in = 16'h00ff, imm_sum, vec_addr;
  cfm_op_e op_code = OP_NONE;
  logic pready, pslverr, cond_lt, cond_le, imm_done, push_req, vec_req;
  logic vec_brk, ir_load, clk_gate, e;
  logic [7:0] res, flags, ir_value;
  logic [2:0] irq_id;
  int miscompares = 0, n_compared = 0;

  cfm_flag_ctl i_cfm_flag_ctl (.clock(clock), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_valid(op_valid), .op_code(op_code), .op_a(op_a), .op_b(op_b),
    .instr_last(instr_last), .res(res), .flags(flags), .cond_lt(cond_lt),
    .cond_le(cond_le), .sp_in(sp_in), .hx_in(hx_in), .imm_sum(imm_sum),
    .imm_done(imm_done), .irq_req(irq_req), .ext_irq(ext_irq),
    .brk_req(brk_req), .push_req(push_req), .push_done(push_done),
    .vec_req(vec_req), .vec_done(vec_done), .vec_brk(vec_brk),
    .vec_addr(vec_addr), .irq_id(irq_id), .ir_load(ir_load),
    .ir_value(ir_value), .clk_gate(clk_gate));

  initial begin
    forever #25 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic step;
    @(posedge clock);
  endtask : step

  // Request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    step();
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    step();
    penable <= 1'b1;
    do step(); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic do_op(input cfm_op_e op, input logic [7:0] a,
                       input logic [7:0] b);
    step();
    op_valid <= 1'b1;
    op_code <= op;
    op_a <= a;
    op_b <= b;
    step();
    op_valid <= 1'b0;
    #1;
  endtask : do_op

  // Answers push and vector requests of one entry
  task automatic serve(input logic [2:0] id, input logic chk_id);
    int n;
    n = 0;
    while (push_req !== 1'b1 && n < 8) begin
      step(); #1; n++;
    end
    chk("push_req", push_req, 1);
    chk("mask_in_push", flags[`CFM_BIT_I], 0);
    if (chk_id) chk("irq_id", irq_id, id);
    step(); push_done <= 1'b1;
    step(); push_done <= 1'b0;
    #1;
    n = 0;
    while (vec_req !== 1'b1 && n < 8) begin
      step(); #1; n++;
    end
    chk("vec_req", vec_req, 1);
    chk("mask_in_vec", flags[`CFM_BIT_I], 1);
    step(); vec_done <= 1'b1;
    step(); vec_done <= 1'b0;
  endtask : serve

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_bus;
    #1;
    chk("flags_rst", flags, `CFM_FLAGS_RST);
    apb(1'b0, `CFM_FLAGS_OFS, 0);
    chk("rd_flags", q, 32'h68);
    apb(1'b0, `CFM_OSC_OFS, 0);
    chk("osc_rst", q, `CFM_OSC_DLY_CYC);
    apb(1'b0, 8'h10, 0);
    chk("unmapped_err", e, 1);
    chk("unmapped_rd", q, 0);
    apb(1'b1, `CFM_FLAGS_OFS, 32'h0);
    apb(1'b0, `CFM_FLAGS_OFS, 0);
    chk("wr_flags0", q, 32'h68);
    apb(1'b1, `CFM_FLAGS_OFS, 32'hff);
    apb(1'b0, `CFM_FLAGS_OFS, 0);
    chk("wr_flagsff", q, 32'hff);
    apb(1'b0, `CFM_STAT_OFS, 0);
    chk("status_rst", q, 32'h0);
    apb(1'b1, `CFM_STAT_OFS, 32'hffff);
    apb(1'b0, `CFM_STAT_OFS, 0);
    chk("status_ro", q, 32'h0);
  endtask : t_reset_bus

  // Flags chain from row to row; carry-in rows rely on the row before
  task automatic t_alu;
    cfm_op_e ops[14] = '{OP_ADD, OP_ADD, OP_ADC, OP_SUB, OP_ADD, OP_DEC_ADJ,
                         OP_ASL, OP_AND, OP_SUB, OP_BTST, OP_SBC, OP_ROR,
                         OP_ROL, OP_EOR};
    logic [7:0] ta[14] = '{8'h7f, 8'hff, 8'h0e, 8'h00, 8'h09, 8'h12, 8'h81,
                           8'hf0, 8'h80, 8'h08, 8'h10, 8'h01, 8'h40, 8'hff};
    logic [7:0] tb[14] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h09, 8'h00, 8'h00,
                           8'h0f, 8'h01, 8'h03, 8'h01, 8'h00, 8'h00, 8'h0f};
    logic [7:0] tr[14] = '{8'h80, 8'h00, 8'h10, 8'hff, 8'h12, 8'h18, 8'h02,
                           8'h00, 8'h7f, 8'h08, 8'h0e, 8'h00, 8'h81, 8'hf0};
    logic [7:0] tm[14] = '{8'hff, 8'hff, 8'hff, 8'h87, 8'hff, 8'h07, 8'h07,
                           8'h06, 8'h80, 8'h01, 8'h87, 8'h87, 8'h87, 8'h86};
    logic [7:0] tf[14] = '{8'hfc, 8'h7b, 8'h78, 8'h05, 8'h78, 8'h00, 8'h01,
                           8'h02, 8'h80, 8'h01, 8'h00, 8'h83, 8'h84, 8'h04};
    for (int i = 0; i < 14; i++) begin
      do_op(ops[i], ta[i], tb[i]);
      chk("alu_res", res, tr[i]);
      chk("alu_flags", flags & tm[i], tf[i]);
    end
    chk("cond_lt", cond_lt, 1);
    chk("cond_le", cond_le, 1);
  endtask : t_alu

  task automatic t_irq;
    step();
    irq_req <= 8'h06;
    instr_last <= 1'b1;
    repeat (3) begin
      step(); #1;
      chk("masked", push_req, 0);
    end
    do_op(OP_CLR_MASK, 8'h00, 8'h00);
    chk("cli", flags[`CFM_BIT_I], 0);
    step();
    irq_req <= 8'h00;
    instr_last <= 1'b0;
    serve(3'd1, 1'b1);
    chk("vec_brk_irq", vec_brk, 0);
    do_op(OP_RET_IRQ, 8'h00, 8'h60);
    chk("rti_flags", flags, 8'h60);
  endtask : t_irq

  task automatic t_imm;
    cfm_op_e ops[2] = '{OP_SP_ADD, OP_IX_ADD};
    logic [7:0] im[2] = '{8'hfe, 8'h7f};
    logic [15:0] ex[2] = '{16'h0ffe, 16'h017e};
    for (int i = 0; i < 2; i++) begin
      do_op(ops[i], im[i], im[i]);
      chk("imm_sum", imm_sum, ex[i]);
      chk("imm_done1", imm_done, 0);
      step(); #1;
      chk("imm_done2", imm_done, 1);
      step(); #1;
      chk("imm_done3", imm_done, 0);
      chk("imm_flags", flags, 8'h60);
    end
    do_op(OP_TAP, 8'h00, 8'h1f);
    chk("tap_flags", flags, 8'h7f);
  endtask : t_imm

  task automatic t_sleep;
    int n;
    do_op(OP_SEI, 8'h00, 8'h00);
    do_op(OP_WAIT, 8'h00, 8'h00);
    chk("wait_gate", clk_gate, 1);
    chk("wait_mask", flags[`CFM_BIT_I], 0);
    step();
    irq_req <= 8'h01;
    push_done <= 1'b1;
    vec_done <= 1'b1;
    step();
    irq_req <= 8'h00;
    step(); #1;
    chk("wake_gate", clk_gate, 0);
    chk("wake_mask", flags[`CFM_BIT_I], 0);
    repeat (4) step();
    push_done <= 1'b0;
    vec_done <= 1'b0;
    apb(1'b1, `CFM_OSC_OFS, 32'h4);
    do_op(OP_SEI, 8'h00, 8'h00);
    do_op(OP_STOP, 8'h00, 8'h00);
    chk("stop_gate", clk_gate, 1);
    chk("stop_mask", flags[`CFM_BIT_I], 0);
    step();
    ext_irq <= 1'b1;
    step();
    ext_irq <= 1'b0;
    n = 0;
    #1;
    while (clk_gate === 1'b1 && n < 20) begin
      step(); #1; n++;
    end
    chk("osc_delay", n, 4);
    chk("stop_exit_mask", flags[`CFM_BIT_I], 0);
  endtask : t_sleep

  // Normal vector first, then monitor mode
  task automatic t_break;
    logic [15:0] v[2] = '{`CFM_BRK_VEC, `CFM_MON_VEC};
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `CFM_CTRL_OFS, i);
      do_op(OP_CLR_MASK, 8'h00, 8'h00);
      step();
      brk_req <= 1'b1;
      instr_last <= 1'b1;
      step();
      instr_last <= 1'b0;
      #1;
      chk("ir_load", ir_load, 1);
      chk("ir_value", ir_value, `CFM_TRAP_OPCODE);
      chk("vec_brk", vec_brk, 1);
      chk("vec_addr", vec_addr, v[i]);
      serve(3'd0, 1'b0);
      do_op(OP_RET_IRQ, 8'h00, 8'h60);
      apb(1'b0, `CFM_STAT_OFS, 0);
      chk("brk_held", q[1], 1);
      step();
      brk_req <= 1'b0;
      do_op(OP_RET_IRQ, 8'h00, 8'h60);
      apb(1'b0, `CFM_STAT_OFS, 0);
      chk("brk_end", q[1], 0);
    end
  endtask : t_break

  // Reset while asleep must set the mask and ungate the clock
  task automatic t_sleep_reset;
    cfm_op_e ops[2] = '{OP_WAIT, OP_STOP};
    for (int i = 0; i < 2; i++) begin
      do_op(ops[i], 8'h00, 8'h00);
      chk("sleep_mask", flags[`CFM_BIT_I], 0);
      step();
      nrst <= 1'b0;
      step();
      #1;
      chk("reset_flags", flags, `CFM_FLAGS_RST);
      chk("reset_gate", clk_gate, 0);
      step();
      nrst <= 1'b1;
    end
  endtask : t_sleep_reset

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end

  initial begin
    repeat (12) step();
    nrst <= 1'b1;
    t_reset_bus();
    t_alu();
    t_irq();
    t_imm();
    t_sleep();
    t_break();
    t_sleep_reset();
    complete_run();
  end
endmodule : cfm_flag_ctl_tb
`default_nettype wire
